/* File: src/cmd_ring_host.sv */
// host end: polls, fills the ring word by word, publishes offset
// assumes the co-processor answers offset reads one cycle after rd
`timescale 1ns/10ps
module cmd_ring_host
#(
  parameter logic [23:0] READ_OFS_ADDR  = 24'h1024e4,
  parameter logic [23:0] WRITE_OFS_ADDR = 24'h1024e8
)
(
  // link
  cmd_ring_if.host          link,
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  // user command stream
  input  wire logic         i_start,
  input  wire logic         i_cmd_valid,
  input  wire logic [31:0]  i_cmd_word,
  input  wire logic         i_cmd_last,
  input  wire logic         i_each,
  output logic              o_cmd_ready,
  output logic              o_busy
);
  cmd_ring_pkg::host_state_t state;
  cmd_ring_pkg::host_state_t next_state;
  logic [11:0] fill_ofs;
  logic [11:0] next_fill_ofs;
  logic [11:0] start_ofs;
  logic [11:0] next_start_ofs;
  logic        phase;
  logic        next_phase;
  logic [11:0] rd_w;
  logic [11:0] next_rd_w;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic        wr;
  logic        next_wr;
  logic        rd;
  logic        next_rd;
  logic        pend;
  logic        next_pend;
  logic        room;

  // leave four bytes unused so the fill never meets the list start
  assign room = (cmd_ring_pkg::ofs_add(fill_ofs, cmd_ring_pkg::RESERVE) != start_ofs);
  assign o_cmd_ready = (state == cmd_ring_pkg::H_FILL) && !pend && room;

  // ****************************************
  // host sequencer
  // ****************************************
  always_comb
  begin
    next_state     = state;
    next_fill_ofs  = fill_ofs;
    next_start_ofs = start_ofs;
    next_phase     = phase;
    next_rd_w      = rd_w;
    next_addr      = addr;
    next_wdata     = wdata;
    next_wr        = 1'b0;
    next_rd        = 1'b0;
    next_pend      = 1'b0;
    case (state)
      cmd_ring_pkg::H_IDLE:
      begin
        if (i_start)
        begin
          next_state = cmd_ring_pkg::H_POLL;
          next_phase = 1'b0;
        end
      end
      cmd_ring_pkg::H_POLL:
      begin
        if (!pend && !rd)
        begin
          next_rd   = 1'b1;
          next_addr = {cmd_ring_pkg::ACC_READ,
                       phase ? READ_OFS_ADDR[21:0] : WRITE_OFS_ADDR[21:0]};
          next_pend = 1'b1;
        end
        else if (pend && !rd)
        begin
          if (!phase)
          begin
            next_rd_w  = link.rdata[11:0];
            next_phase = 1'b1;
          end
          else if (link.rdata[11:0] == rd_w)
          begin
            next_fill_ofs  = rd_w;
            next_start_ofs = rd_w;
            next_state     = cmd_ring_pkg::H_FILL;
          end
          else
          begin
            next_phase = 1'b0;
          end
        end
        else
        begin
          next_pend = pend;
        end
      end
      cmd_ring_pkg::H_FILL:
      begin
        if (pend)
        begin
          next_wr    = 1'b1;
          next_addr  = {cmd_ring_pkg::ACC_WRITE, WRITE_OFS_ADDR[21:0]};
          next_wdata = {20'h00000, fill_ofs};
        end
        else if (i_cmd_valid && room)
        begin
          next_wr       = 1'b1;
          next_addr     = {cmd_ring_pkg::ACC_WRITE, cmd_ring_pkg::RING_BASE[21:0] + {10'h000, fill_ofs}};
          next_wdata    = i_cmd_word;
          next_fill_ofs = cmd_ring_pkg::ofs_add(fill_ofs, cmd_ring_pkg::WORD_BYTES);
          if (i_cmd_last)
          begin
            next_state = cmd_ring_pkg::H_PUBLISH;
          end
          else if (i_each)
          begin
            next_pend = 1'b1;
          end
        end
      end
      cmd_ring_pkg::H_PUBLISH:
      begin
        next_wr    = 1'b1;
        next_addr  = {cmd_ring_pkg::ACC_WRITE, WRITE_OFS_ADDR[21:0]};
        next_wdata = {20'h00000, fill_ofs};
        next_state = cmd_ring_pkg::H_IDLE;
      end
      default:
      begin
        next_state = cmd_ring_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state     <= cmd_ring_pkg::H_IDLE;
      fill_ofs  <= cmd_ring_pkg::OFS_ZERO;
      start_ofs <= cmd_ring_pkg::OFS_ZERO;
      phase     <= 1'b0;
      rd_w      <= cmd_ring_pkg::OFS_ZERO;
      addr      <= 24'h000000;
      wdata     <= 32'h00000000;
      wr        <= 1'b0;
      rd        <= 1'b0;
      pend      <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      fill_ofs  <= next_fill_ofs;
      start_ofs <= next_start_ofs;
      phase     <= next_phase;
      rd_w      <= next_rd_w;
      addr      <= next_addr;
      wdata     <= next_wdata;
      wr        <= next_wr;
      rd        <= next_rd;
      pend      <= next_pend;
    end
  end

  assign link.addr  = addr;
  assign link.wdata = wdata;
  assign link.wr    = wr;
  assign link.rd    = rd;
  assign o_busy     = (state != cmd_ring_pkg::H_IDLE);
endmodule : cmd_ring_host

/* File: shared/cmd_ring_pkg.sv */
// constants and types shared by both ends of the command ring
// assumes one system clock shared by host and co-processor
package cmd_ring_pkg;

  // ****************************************
  // ring geometry
  // ****************************************
  localparam int unsigned     OFS_W        = 12;
  localparam int unsigned     WORD_W       = 32;
  localparam int unsigned     ADDR_W       = 24;
  localparam int unsigned     RING_WORDS   = 1024;
  localparam int unsigned     WIDX_W       = 10;
  localparam logic [23:0]     RING_BASE    = 24'h108000;
  localparam logic [23:0]     RING_TOP     = 24'h108fff;
  localparam logic [11:0]     OFS_MAX      = 12'hfff;
  localparam logic [11:0]     WORD_BYTES   = 12'h004;
  localparam logic [11:0]     OFS_ZERO     = 12'h000;
  localparam logic [1:0]      ALIGN_ZERO   = 2'h0;
  localparam logic [11:0]     RESERVE      = 12'h004;

  // ****************************************
  // host access address prefix
  // ****************************************
  localparam logic [1:0]      ACC_READ     = 2'h0;
  localparam logic [1:0]      ACC_WRITE    = 2'h2;

  // ****************************************
  // display list memory
  // ****************************************
  localparam int unsigned     DL_W         = 11;
  localparam logic [10:0]     DL_ZERO      = 11'h000;
  localparam logic [10:0]     DL_ONE       = 11'h001;
  localparam logic [31:0]     BEGIN_LIST   = 32'hffffff00;

  // ****************************************
  // host sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    H_IDLE,
    H_POLL,
    H_FILL,
    H_PUBLISH
  } host_state_t;

  // offset advance with wrap at ring end
  function automatic logic [11:0] ofs_add(input logic [11:0] ofs, input logic [11:0] len);
    ofs_add = ofs + len;
  endfunction : ofs_add

endpackage : cmd_ring_pkg

/* File: shared/cmd_ring_if.sv */
// link between host and co-processor of the command ring
// assumes a single clock and synchronous reset driven by the bench
`timescale 1ns/10ps
interface cmd_ring_if
(
  input wire logic i_clk_sys,
  input wire logic i_srst
);
  logic [23:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;

  modport coproc
  (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata
  );

  modport host
  (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata
  );
endinterface : cmd_ring_if

/* File: src/cmd_ring_mem.sv */
// ring storage of 1024 command words, one write and one read port
// assumes word addresses already reduced to the ring
`timescale 1ns/10ps
module cmd_ring_mem
(
  // clock
  input  wire logic        i_clk_sys,
  // write port
  input  wire logic        i_we,
  input  wire logic [9:0]  i_waddr,
  input  wire logic [31:0] i_wdata,
  // read port
  input  wire logic [9:0]  i_raddr,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [cmd_ring_pkg::RING_WORDS];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : cmd_ring_mem

/* File: src/cmd_ring_coproc.sv */
// co-processor end: ring memory, offset registers, consumer
// assumes the host keeps the fill discipline of the ring
`timescale 1ns/10ps

module cmd_ring_coproc
#(
  parameter logic [23:0] READ_OFS_ADDR  = 24'h1024e4,
  parameter logic [23:0] WRITE_OFS_ADDR = 24'h1024e8
)
(
  // link
  cmd_ring_if.coproc        link,
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  // display list output
  output logic              o_dl_we,
  output logic      [10:0]  o_dl_addr,
  output logic      [31:0]  o_dl_data,
  // status
  output logic      [11:0]  o_read_ofs,
  output logic      [11:0]  o_write_ofs,
  output logic              o_empty
);
  logic [11:0] read_ofs;
  logic [11:0] next_read_ofs;
  logic [11:0] write_ofs;
  logic [11:0] next_write_ofs;
  logic        fetch;
  logic        next_fetch;
  logic [10:0] dl_addr;
  logic [10:0] next_dl_addr;
  logic        dl_we;
  logic        next_dl_we;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] ring_q;
  logic        in_ring;
  logic        ring_we;
  logic        empty;
  logic        ofs_wr;
  logic        rofs_rd;
  logic        wofs_rd;
  logic        any_rd;
  logic [31:0] dl_data;
  logic [31:0] next_dl_data;

  // ****************************************
  // host access decode
  // ****************************************
  function automatic logic reg_hit
  (
    input logic [23:0] addr,
    input logic [1:0]  kind,
    input logic [23:0] target
  );
    reg_hit = (addr[23:22] == kind) && (addr[21:0] == target[21:0]);
  endfunction : reg_hit

  assign in_ring = (link.addr[21:0] >= cmd_ring_pkg::RING_BASE[21:0])
                && (link.addr[21:0] <= cmd_ring_pkg::RING_TOP[21:0]);
  assign ring_we = link.wr && (link.addr[23:22] == cmd_ring_pkg::ACC_WRITE) && in_ring;
  assign empty   = (read_ofs == write_ofs);

  assign ofs_wr  = link.wr && reg_hit(link.addr, cmd_ring_pkg::ACC_WRITE, WRITE_OFS_ADDR);
  assign rofs_rd = link.rd && reg_hit(link.addr, cmd_ring_pkg::ACC_READ, READ_OFS_ADDR);
  assign wofs_rd = link.rd && reg_hit(link.addr, cmd_ring_pkg::ACC_READ, WRITE_OFS_ADDR);
  assign any_rd  = link.rd && (link.addr[23:22] == cmd_ring_pkg::ACC_READ);

  cmd_ring_mem u_mem
  (
    .i_clk_sys (i_clk_sys),
    .i_we      (ring_we),
    .i_waddr   (link.addr[11:2]),
    .i_wdata   (link.wdata),
    .i_raddr   (read_ofs[11:2]),
    .o_rdata   (ring_q)
  );

  // ****************************************
  // write offset register and read answers
  // ****************************************
  always_comb
  begin
    next_write_ofs = write_ofs;
    next_rdata     = rdata;
    // only the offset register write moves the write offset
    if (ofs_wr)
    begin
      next_write_ofs = {link.wdata[11:2], cmd_ring_pkg::ALIGN_ZERO};
    end
    if (rofs_rd)
    begin
      next_rdata = {20'h00000, read_ofs};
    end
    else if (wofs_rd)
    begin
      next_rdata = {20'h00000, write_ofs};
    end
    else if (any_rd)
    begin
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      write_ofs <= cmd_ring_pkg::OFS_ZERO;
      rdata     <= 32'h00000000;
    end
    else
    begin
      write_ofs <= next_write_ofs;
      rdata     <= next_rdata;
    end
  end

  // ****************************************
  // consumer
  // ****************************************
  // memory read takes a cycle: fetch issues, then consume
  always_comb
  begin
    next_read_ofs = read_ofs;
    next_fetch    = 1'b0;
    if (fetch)
    begin
      next_read_ofs = cmd_ring_pkg::ofs_add(read_ofs, cmd_ring_pkg::WORD_BYTES);
    end
    else if (!empty)
    begin
      next_fetch = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      read_ofs <= cmd_ring_pkg::OFS_ZERO;
      fetch    <= 1'b0;
    end
    else
    begin
      read_ofs <= next_read_ofs;
      fetch    <= next_fetch;
    end
  end

  // ****************************************
  // display list writer
  // ****************************************
  always_comb
  begin
    next_dl_we   = fetch;
    next_dl_addr = dl_addr;
    next_dl_data = dl_data;
    if (fetch)
    begin
      next_dl_data = ring_q;
      if (ring_q == cmd_ring_pkg::BEGIN_LIST)
      begin
        next_dl_addr = cmd_ring_pkg::DL_ZERO;
      end
      else
      begin
        next_dl_addr = dl_addr + cmd_ring_pkg::DL_ONE;
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      dl_we   <= 1'b0;
      dl_addr <= cmd_ring_pkg::DL_ZERO;
      dl_data <= 32'h00000000;
    end
    else
    begin
      dl_we   <= next_dl_we;
      dl_addr <= next_dl_addr;
      dl_data <= next_dl_data;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.rdata  = rdata;
  assign o_dl_we     = dl_we;
  assign o_dl_addr   = dl_addr;
  assign o_dl_data   = dl_data;
  assign o_read_ofs  = read_ofs;
  assign o_write_ofs = write_ofs;
  assign o_empty     = empty;
endmodule : cmd_ring_coproc

/* File: tb/cmd_ring_monitor.sv */
// checker on the link between host and co-processor
// assumes it is instantiated beside cmd_ring_if in the bench
`timescale 1ns/10ps
module cmd_ring_monitor
#(
  parameter logic [23:0] READ_OFS_ADDR  = 24'h1024e4,
  parameter logic [23:0] WRITE_OFS_ADDR = 24'h1024e8
)
(
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic [23:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata
);
  // ****************************************
  // expected fill and published offsets
  // ****************************************
  logic [11:0] fill;
  logic [11:0] next_fill;
  logic [11:0] pub;
  logic [11:0] next_pub;
  logic        ring_wr;
  logic        pub_wr;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  assign ring_wr = wr && (addr[21:12] == cmd_ring_pkg::RING_BASE[21:12]);
  assign pub_wr  = wr && (addr[21:0] == WRITE_OFS_ADDR[21:0]);

  always_comb
  begin
    next_fill = ring_wr ? addr[11:0] + cmd_ring_pkg::WORD_BYTES : fill;
    next_pub  = pub_wr ? wdata[11:0] : pub;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      fill <= 12'h000;
      pub  <= 12'h000;
    end
    else
    begin
      fill <= next_fill;
      pub  <= next_pub;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_wr_prefix;
    wr |-> addr[23:22] == cmd_ring_pkg::ACC_WRITE;
  endproperty
  a_wr_prefix: assert property (p_wr_prefix)
    else $error("write without write prefix");
  property p_rd_prefix;
    rd |-> addr[23:22] == cmd_ring_pkg::ACC_READ;
  endproperty
  a_rd_prefix: assert property (p_rd_prefix)
    else $error("read without read prefix");
  property p_wr_target;
    wr |-> ring_wr || pub_wr;
  endproperty
  a_wr_target: assert property (p_wr_target)
    else $error("write outside ring and offset register");
  property p_word_align;
    ring_wr |-> addr[1:0] == cmd_ring_pkg::ALIGN_ZERO;
  endproperty
  a_word_align: assert property (p_word_align)
    else $error("ring write not word aligned");
  property p_fill_seq;
    ring_wr |-> addr[11:0] == fill;
  endproperty
  a_fill_seq: assert property (p_fill_seq)
    else $error("ring write out of sequence");
  property p_pub_value;
    pub_wr |-> wdata == {20'h00000, fill};
  endproperty
  a_pub_value: assert property (p_pub_value)
    else $error("published offset not past last word");
  property p_wofs_read;
    rd && addr[21:0] == WRITE_OFS_ADDR[21:0] |=> rdata == {20'h00000, $past(pub)};
  endproperty
  a_wofs_read: assert property (p_wofs_read)
    else $error("write offset moved without publish");
  property p_rofs_shape;
    rd && addr[21:0] == READ_OFS_ADDR[21:0] |=> rdata[31:12] == 20'h00000 && rdata[1:0] == 2'h0;
  endproperty
  a_rofs_shape: assert property (p_rofs_shape)
    else $error("read offset not an aligned ring offset");
endmodule : cmd_ring_monitor

/* File: tb/testbench.sv */
// self-checking bench: host and co-processor joined by cmd_ring_if
// assumes a 20 MHz clock and synchronous active high reset
`timescale 1ns/10ps
module testbench;
  logic        clk;
  logic        srst;
  logic        start;
  logic        cmd_valid;
  logic [31:0] cmd_word;
  logic        cmd_last;
  logic        each;
  logic        cmd_ready;
  logic        busy;
  logic        dl_we;
  logic [10:0] dl_addr;
  logic [31:0] dl_data;
  logic [11:0] read_ofs;
  logic [11:0] write_ofs;
  logic        empty;
  logic [11:0] exp_ofs;
  logic [31:0] dl_q[$];
  logic [10:0] dla_q[$];
  int          fail_count;
  int          n_compared;

  cmd_ring_if link (.i_clk_sys(clk), .i_srst(srst));
  cmd_ring_host u_cmd_ring_host (.link(link), .i_clk_sys(clk), .i_srst(srst), .i_start(start),
    .i_cmd_valid(cmd_valid), .i_cmd_word(cmd_word), .i_cmd_last(cmd_last), .i_each(each),
    .o_cmd_ready(cmd_ready), .o_busy(busy));
  cmd_ring_coproc u_cmd_ring_coproc (.link(link), .i_clk_sys(clk), .i_srst(srst), .o_dl_we(dl_we),
    .o_dl_addr(dl_addr), .o_dl_data(dl_data), .o_read_ofs(read_ofs), .o_write_ofs(write_ofs),
    .o_empty(empty));
  cmd_ring_monitor u_cmd_ring_monitor (.i_clk_sys(clk), .i_srst(srst), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

  always #25 clk = ~clk;

  always @(negedge clk)
    if (dl_we === 1'b1)
    begin
      dl_q.push_back(dl_data);
      dla_q.push_back(dl_addr);
    end

  // ****************************************
  // compare and closing tasks
  // ****************************************
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string name, input logic exp, input logic got);
    chk32(name, {31'h0, exp}, {31'h0, got});
  endtask : chk1

  task automatic wait_ofs(input logic [11:0] ofs);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (!(read_ofs === ofs && write_ofs === ofs) && k < 5000);
    if (k >= 5000)
    begin
      fail_count++;
      summarize();
    end
  endtask : wait_ofs

  // ****************************************
  // scenarios
  // ****************************************
  task automatic check_reset();
    chk32("read_ofs", 32'h0, {20'h0, read_ofs});
    chk32("write_ofs", 32'h0, {20'h0, write_ofs});
    chk1("empty", 1'b1, empty);
    chk1("busy", 1'b0, busy);
  endtask : check_reset

  task automatic run_list(input int n, input logic per_word);
    logic [11:0] base;
    int          i;
    int          k;
    base = exp_ofs;
    dl_q.delete();
    dla_q.delete();
    each = per_word;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < n; i++)
    begin
      cmd_valid = 1'b1;
      cmd_word = (i == 0) ? cmd_ring_pkg::BEGIN_LIST : {20'h02000, i[11:0]};
      cmd_last = (i == n - 1);
      k = 0;
      #1;
      while (cmd_ready !== 1'b1 && k < 5000)
      begin
        @(negedge clk);
        #1;
        k++;
      end
      if (k >= 5000)
      begin
        fail_count++;
        summarize();
      end
      @(negedge clk);
      exp_ofs = exp_ofs + 12'h004;
      if (per_word)
      begin
        cmd_valid = 1'b0;
        wait_ofs(exp_ofs);
        @(negedge clk);
        chk32("read_ofs", {20'h0, exp_ofs}, {20'h0, read_ofs});
        chk32("dl_count", i + 1, dl_q.size());
      end
      else if (i != n - 1)
      begin
        chk32("read_ofs", {20'h0, base}, {20'h0, read_ofs});
        chk32("write_ofs", {20'h0, base}, {20'h0, write_ofs});
        chk1("empty", 1'b1, empty);
      end
    end
    cmd_valid = 1'b0;
    cmd_last = 1'b0;
    wait_ofs(exp_ofs);
    @(negedge clk);
    chk32("read_ofs", {20'h0, exp_ofs}, {20'h0, read_ofs});
    chk32("write_ofs", {20'h0, exp_ofs}, {20'h0, write_ofs});
    chk1("empty", 1'b1, empty);
    chk32("dl_count", n, dl_q.size());
    for (i = 0; i < n && i < dl_q.size(); i++)
    begin
      chk32("dl_data", (i == 0) ? cmd_ring_pkg::BEGIN_LIST : {20'h02000, i[11:0]}, dl_q[i]);
      chk32("dl_addr", i, {21'h0, dla_q[i]});
    end
    chk1("busy", 1'b0, busy);
  endtask : run_list

  task automatic scen_batch();
    run_list(5, 1'b0);
  endtask : scen_batch

  task automatic scen_single();
    run_list(1, 1'b0);
  endtask : scen_single

  task automatic scen_wrap();
    run_list(1023, 1'b0);
  endtask : scen_wrap

  task automatic scen_each();
    run_list(3, 1'b1);
  endtask : scen_each

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    start = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 32'h0;
    cmd_last = 1'b0;
    each = 1'b0;
    exp_ofs = 12'h000;
    fail_count = 0;
    n_compared = 0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check_reset();
    scen_batch();
    scen_single();
    scen_wrap();
    scen_each();
    summarize();
  end
endmodule : testbench
